// ===== rtl/bes_pkg.sv
package bes_pkg;

    // Clock figures
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Maximum duty-cycle enforcement (times in ns)
    localparam int unsigned MIN_OFF_NS     = 150;
    localparam int unsigned DROPOUT_WIN_NS = 7500;
    localparam int unsigned FORCE_OFF_NS   = 60;
    // Least times round up, windows round down
    localparam int unsigned MIN_OFF_CYC    = (MIN_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DROPOUT_WIN_CYC = (DROPOUT_WIN_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned FORCE_OFF_CYC  = (FORCE_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Soft-start ramp: 0 V to 5.15 V (in mV) over 8 ms
    localparam int unsigned SOFT_START_MS  = 8;
    localparam int unsigned VOUT_TARGET_MV = 5150;
    localparam longint unsigned SOFT_START_CYC =
        (64'(SOFT_START_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);

    // Fixed stand-alone retry interval
    localparam int unsigned RETRY_FIXED_MS = 2000;
    localparam longint unsigned RETRY_FIXED_CYC =
        (64'(RETRY_FIXED_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);

    // Discharge reset timer default (cycles)
    localparam longint unsigned DISCHARGE_CYC = 64'd250000;

    localparam int unsigned TIMER_W = 32;

    typedef enum logic [2:0] {
        BES_OFF     = 3'b000,
        BES_RAMP    = 3'b001,
        BES_RUN     = 3'b011,
        BES_DISCH   = 3'b010,
        BES_RETRY   = 3'b110
    } bes_state_t;

    typedef struct packed {
        logic uv;
        logic ov;
        logic oc;
        logic ot;
    } bes_fault_t;

endpackage

// ===== rtl/bes_timer.sv
`timescale 1ns/10ps
module bes_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] load_i,
    output logic              busy_o
);
    logic [W-1:0] count;

    if (W < 2) begin : g_bad_width
        $error("bes_timer: width too small");
    end

    // Restart reloads even while busy
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (ce_i) begin
            if (start_i) begin
                count <= load_i;
            end else if (count != '0) begin
                count <= count - W'(1);
            end
        end
    end

    assign busy_o = (count != '0);
endmodule

// ===== rtl/bes_sequencer.sv
`timescale 1ns/10ps
// Contract
// RULE1: System enable low puts device in standby
// RULE2: Flag unconfigured on interrupt after system reset
// RULE3: Converter off until setup_done written one
// RULE4: converter_run is pin AND bit
// RULE5: Stand-alone holds converter_enable_bit high
// RULE6: Low enable pin overrides serial enable
// RULE7: Enable pin low at startup keeps off
// RULE8: IO rail overvoltage disables USB switches
// RULE9: Regulator needs enable and supply; UVLO gates
// RULE10: Measure off-time every switching cycle
// RULE11: Persistent minimum off-time forces periodic low-side
// RULE12: Soft-start ramps target to 5.15V, 8ms
// RULE13: Discharge active whenever converter disabled
// RULE14: Discharge starts reset timer blocking restart
// RULE15: Any fault resets the converter
// RULE16: Configurable retry timer after fault clears
// RULE17: Fixed 2s retry after fault, stand-alone
// RULE18: Stand-alone 2s retry after run falls
// RULE19: System reset clears setup_done
module bes_sequencer #(
    parameter bit          STANDALONE      = 1'b0,
    parameter int unsigned SOFT_START_CYC  = 32'(bes_pkg::SOFT_START_CYC),
    parameter int unsigned RETRY_FIXED_CYC = 32'(bes_pkg::RETRY_FIXED_CYC),
    parameter int unsigned DISCHARGE_CYC   = 32'(bes_pkg::DISCHARGE_CYC)
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire logic              system_enable_pin_i,
    input  wire logic              converter_enable_pin_i,
    input  wire logic              converter_enable_bit_i,
    input  wire logic              setup_done_set_i,
    input  wire logic              irq_clear_i,
    input  wire logic              switch_supply_ok_i,
    input  wire logic              regulator_ok_i,
    input  wire logic              io_rail_ovlo_i,
    input  wire bes_pkg::bes_fault_t fault_i,
    input  wire logic [31:0]       retry_cfg_cyc_i,
    input  wire logic              pwm_high_i,
    output logic                   standby_o,
    output logic                   regulator_en_o,
    output logic                   irq_out_n_o,
    output logic                   setup_done_o,
    output logic                   converter_on_o,
    output logic [12:0]            vout_target_mv_o,
    output logic                   discharge_o,
    output logic                   usb_switch_en_o,
    output logic                   force_low_side_o
);
    localparam int unsigned TW = bes_pkg::TIMER_W;

    if (SOFT_START_CYC < 1 || RETRY_FIXED_CYC < 1 || DISCHARGE_CYC < 1) begin : g_bad_counts
        $error("bes_sequencer: timer counts must be nonzero");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_sync <= 2'h0;
        else          rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    localparam int unsigned NP = 6;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] pin_s1;
    logic [NP-1:0] pin_s2;
    assign pin_raw = {system_enable_pin_i, converter_enable_pin_i, switch_supply_ok_i,
                      regulator_ok_i, io_rail_ovlo_i, pwm_high_i};
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (ce_i) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end
    wire sys_en   = pin_s2[5];
    wire conv_pin = pin_s2[4];
    wire sup_ok   = pin_s2[3];
    wire reg_ok   = pin_s2[2];
    wire io_ovlo  = pin_s2[1];
    wire pwm_high = pin_s2[0];

    // Faults from analog comparators also cross in
    logic [3:0] flt_s1;
    logic [3:0] flt_s2;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flt_s1 <= '0;
            flt_s2 <= '0;
        end else if (ce_i) begin
            flt_s1 <= fault_i;
            flt_s2 <= flt_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power gating and configuration
    wire reg_en  = sys_en && sup_ok;                            // RULE9
    wire alive   = reg_en && reg_ok;                            // RULE9
    wire any_flt = |flt_s2;

    logic alive_q;
    logic setup_done;
    logic irq_n;
    wire  sys_reset_evt = alive_q && !alive;

    // Unconfigured after any system reset
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            alive_q    <= 1'b0;
            setup_done <= 1'b0;
            irq_n      <= 1'b1;
        end else if (ce_i) begin
            alive_q <= alive;
            if (!alive) begin
                setup_done <= 1'b0;                             // RULE19
            end else if (setup_done_set_i) begin
                setup_done <= 1'b1;
            end
            // Raise wins over a same-cycle clear
            if (alive && !alive_q && !STANDALONE) begin
                irq_n <= 1'b0;                                  // RULE2
            end else if (irq_clear_i || sys_reset_evt) begin
                irq_n <= 1'b1;
            end
        end
    end

    wire en_bit     = STANDALONE ? 1'b1 : converter_enable_bit_i;     // RULE5
    wire conv_run   = conv_pin && en_bit;                              // RULE4 RULE6 RULE7
    wire cfg_ok     = STANDALONE ? 1'b1 : setup_done;                  // RULE3
    wire want_on    = alive && conv_run && cfg_ok && !any_flt;         // RULE15

    ////////////////////////////////////////////////////////////////////////
    // Restart timers
    logic run_q;
    logic flt_q;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            flt_q <= 1'b0;
        end else if (ce_i) begin
            run_q <= conv_run;
            flt_q <= any_flt;
        end
    end
    wire flt_clear = flt_q && !any_flt;
    wire run_fall  = run_q && !conv_run;

    bes_pkg::bes_state_t state;
    bes_pkg::bes_state_t next_state;
    wire disch_start = (state == bes_pkg::BES_RAMP || state == bes_pkg::BES_RUN)
                       && !want_on;

    logic disch_busy;
    logic flt_busy;
    logic run_busy;

    bes_timer #(.W(TW)) u_disch (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .start_i   (disch_start),                               // RULE14
        .load_i    (TW'(DISCHARGE_CYC)),
        .busy_o    (disch_busy)
    );
    bes_timer #(.W(TW)) u_fault (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .start_i   (flt_clear),                                  // RULE16 RULE17
        .load_i    (STANDALONE ? TW'(RETRY_FIXED_CYC) : retry_cfg_cyc_i),
        .busy_o    (flt_busy)
    );
    bes_timer #(.W(TW)) u_run (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .start_i   (run_fall && STANDALONE),                     // RULE18
        .load_i    (TW'(RETRY_FIXED_CYC)),
        .busy_o    (run_busy)
    );
    // Retry load edge blocks too: the busy flag shows one edge late
    wire blocked = disch_busy || flt_busy || run_busy || flt_clear;         // RULE16 RULE17

    ////////////////////////////////////////////////////////////////////////
    // Converter state machine and soft-start
    logic [TW-1:0] ramp_cnt;
    wire ramp_done = ramp_cnt >= TW'(SOFT_START_CYC - 1);

    always_comb begin
        next_state = state;
        case (state)
            bes_pkg::BES_OFF:   if (want_on && !blocked) next_state = bes_pkg::BES_RAMP;
            bes_pkg::BES_RAMP:  if (!want_on) next_state = bes_pkg::BES_DISCH;
                                else if (ramp_done) next_state = bes_pkg::BES_RUN;
            bes_pkg::BES_RUN:   if (!want_on) next_state = bes_pkg::BES_DISCH;
            bes_pkg::BES_DISCH: if (!disch_start && !disch_busy) next_state = bes_pkg::BES_RETRY;
            bes_pkg::BES_RETRY: if (!blocked) next_state = bes_pkg::BES_OFF;
            default:            next_state = bes_pkg::BES_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state    <= bes_pkg::BES_OFF;
            ramp_cnt <= '0;
        end else if (ce_i) begin
            state <= next_state;
            if (state == bes_pkg::BES_RAMP) ramp_cnt <= ramp_cnt + TW'(1);  // RULE12
            else                            ramp_cnt <= '0;
        end
    end

    // Linear ramp; 64-bit product avoids overflow
    wire [63:0] ramp_prod = 64'(ramp_cnt) * 64'(bes_pkg::VOUT_TARGET_MV);
    wire [12:0] ramp_mv   = 13'(ramp_prod / 64'(SOFT_START_CYC));
    wire [12:0] next_vout = (state == bes_pkg::BES_RUN) ? 13'(bes_pkg::VOUT_TARGET_MV) :
                            (state == bes_pkg::BES_RAMP) ? ramp_mv : 13'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Off-time monitor for maximum duty cycle
    logic [15:0] off_cnt;
    logic [15:0] win_cnt;
    logic [15:0] force_cnt;
    logic        pwm_high_q;
    logic        short_seen;
    wire cyc_start = pwm_high && !pwm_high_q;
    wire off_short = cyc_start && (off_cnt < 16'(bes_pkg::MIN_OFF_CYC + 1));  // RULE10
    wire win_end   = win_cnt >= 16'(bes_pkg::DROPOUT_WIN_CYC - 1);
    wire switching = (state == bes_pkg::BES_RAMP || state == bes_pkg::BES_RUN);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt    <= '0;
            win_cnt    <= '0;
            force_cnt  <= '0;
            pwm_high_q <= 1'b0;
            short_seen <= 1'b0;
        end else if (ce_i) begin
            pwm_high_q <= pwm_high;
            if (pwm_high) off_cnt <= '0;                              // RULE10
            else if (off_cnt != 16'hFFFF) off_cnt <= off_cnt + 16'h0001;
            // A long off-time restarts the persistence window
            if (!switching || (cyc_start && !off_short)) begin
                win_cnt    <= '0;
                short_seen <= 1'b0;
            end else if (win_end) begin
                win_cnt    <= '0;
                short_seen <= 1'b0;
                if (short_seen || off_short) force_cnt <= 16'(bes_pkg::FORCE_OFF_CYC);  // RULE11
            end else begin
                win_cnt <= win_cnt + 16'h0001;
                if (off_short) short_seen <= 1'b1;
            end
            if (force_cnt != 16'h0000 && !(win_end && switching)) force_cnt <= force_cnt - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_o        <= 1'b1;
            regulator_en_o   <= 1'b0;
            irq_out_n_o      <= 1'b1;
            setup_done_o     <= 1'b0;
            converter_on_o   <= 1'b0;
            vout_target_mv_o <= 13'h0000;
            discharge_o      <= 1'b1;
            usb_switch_en_o  <= 1'b0;
            force_low_side_o <= 1'b0;
        end else if (ce_i) begin
            standby_o        <= !sys_en;                                    // RULE1
            regulator_en_o   <= reg_en;                                     // RULE9
            irq_out_n_o      <= irq_n;                                      // RULE2
            setup_done_o     <= setup_done;
            converter_on_o   <= (next_state == bes_pkg::BES_RAMP) ||
                                (next_state == bes_pkg::BES_RUN);           // RULE4
            vout_target_mv_o <= next_vout;                                  // RULE12
            discharge_o      <= !((next_state == bes_pkg::BES_RAMP) ||
                                  (next_state == bes_pkg::BES_RUN));        // RULE13
            usb_switch_en_o  <= alive && !io_ovlo;                          // RULE8
            force_low_side_o <= (force_cnt != 16'h0000) && switching;       // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    a_on_needs_run: assert property (converter_on_o |-> $past(conv_run))      // RULE4
        else $error("converter on without run");
    a_on_needs_cfg: assert property (converter_on_o |-> $past(cfg_ok))       // RULE3
        else $error("converter on before setup done");
    a_disch_off: assert property (ce_i && !converter_on_o |-> discharge_o)  // RULE13
        else $error("discharge not active while off");
    a_standby_level: assert property (ce_i |=> standby_o == !$past(sys_en))  // RULE1
        else $error("standby mismatch");
    a_usb_ovlo: assert property (ce_i && io_ovlo |=> !usb_switch_en_o)       // RULE8
        else $error("USB switches on during overvoltage");
    a_fault_reset: assert property (ce_i && any_flt && switching |=> !switching)  // RULE15
        else $error("fault did not reset converter");
    a_disch_blocks: assert property (disch_busy |-> !(next_state == bes_pkg::BES_RAMP))  // RULE14
        else $error("restart during discharge timer");
    a_retry_blocks: assert property (flt_busy && state == bes_pkg::BES_OFF |=> state != bes_pkg::BES_RAMP)  // RULE16
        else $error("restart during retry timer");
    a_retry_start: assert property (ce_i && flt_clear |=> state != bes_pkg::BES_RAMP)  // RULE16
        else $error("restart as retry timer loads");
    a_cfg_cleared: assert property (ce_i && !alive |=> !setup_done)          // RULE19
        else $error("setup_done survived reset");
    a_irq_after_rst: assert property (ce_i && alive && !alive_q && !STANDALONE |=> !irq_n)  // RULE2
        else $error("unconfigured flag not raised");
    a_reg_gate: assert property (ce_i && !sys_en |=> !regulator_en_o)        // RULE9
        else $error("regulator on without system enable");
endmodule

// ===== verification/bes_hub_model.sv
`timescale 1ns/10ps
module bes_hub_model #(
    parameter int unsigned LAG = 3
) (
    input  wire logic sys_clk_i,
    input  wire logic port_on_i,
    input  wire logic slow_i,
    output logic      converter_enable_pin_o
);
    int unsigned wait_cnt;
    logic        pin_q = 1'b0;

    assign converter_enable_pin_o = pin_q;

    // Slow firmware answers a port command late, but never glitches the pin
    always @(negedge sys_clk_i) begin
        if (port_on_i === pin_q) begin
            wait_cnt <= 0;
        end else if (!slow_i || wait_cnt >= LAG) begin
            pin_q <= port_on_i;
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// ===== verification/buck_enable_sequencer_tb.sv
`timescale 1ns/10ps
module buck_enable_sequencer_tb;
    localparam int SS = 50;
    localparam int RT = 60;
    localparam int DC = 40;
    localparam int RC = 30;
    localparam int LIM = DC + RT + RC + 80;

    typedef struct packed {
        logic s, p, r, o, stb, ren;
    } bes_row_t;

    logic clk, rst_n, sys_en, bit_en, set_p, irq_clr, sup_ok, reg_ok, ovlo, pwm;
    logic port_on, slow, pin, standby, reg_en, irq_n, setup_done, conv_on, disch;
    logic usb_en, force_ls, sa_on;
    logic [12:0] vout, v1;
    bes_pkg::bes_fault_t fault;
    int failures, check_count, pwm_mode, pwm_cnt, n;
    // Columns: sys enable, supply ok, regulator ok, io overvoltage, standby, regulator
    bes_row_t rows [4] = '{6'h1A, 6'h28, 6'h3D, 6'h31};

    bes_hub_model bes_hub_model_inst (.sys_clk_i(clk), .port_on_i(port_on), .slow_i(slow),
        .converter_enable_pin_o(pin));

    bes_sequencer #(.STANDALONE(1'b0), .SOFT_START_CYC(SS), .RETRY_FIXED_CYC(RT),
        .DISCHARGE_CYC(DC)) bes_sequencer_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .system_enable_pin_i(sys_en), .converter_enable_pin_i(pin),
        .converter_enable_bit_i(bit_en), .setup_done_set_i(set_p), .irq_clear_i(irq_clr),
        .switch_supply_ok_i(sup_ok), .regulator_ok_i(reg_ok), .io_rail_ovlo_i(ovlo),
        .fault_i(fault), .retry_cfg_cyc_i(32'(RC)), .pwm_high_i(pwm), .standby_o(standby),
        .regulator_en_o(reg_en), .irq_out_n_o(irq_n), .setup_done_o(setup_done),
        .converter_on_o(conv_on), .vout_target_mv_o(vout), .discharge_o(disch),
        .usb_switch_en_o(usb_en), .force_low_side_o(force_ls));

    // Stand-alone copy: its enable bit is tied low but forced high inside, so the pin alone runs it
    bes_sequencer #(.STANDALONE(1'b1), .SOFT_START_CYC(SS), .RETRY_FIXED_CYC(RT),
        .DISCHARGE_CYC(DC)) bes_sequencer_sa_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
        .ce_i(1'b1), .system_enable_pin_i(sys_en), .converter_enable_pin_i(pin),
        .converter_enable_bit_i(1'b0), .setup_done_set_i(set_p), .irq_clear_i(irq_clr),
        .switch_supply_ok_i(sup_ok), .regulator_ok_i(reg_ok), .io_rail_ovlo_i(ovlo),
        .fault_i(fault), .retry_cfg_cyc_i(32'(RC)), .pwm_high_i(pwm), .standby_o(),
        .regulator_en_o(), .irq_out_n_o(), .setup_done_o(), .converter_on_o(sa_on),
        .vout_target_mv_o(), .discharge_o(), .usb_switch_en_o(), .force_low_side_o());

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Mode 1 gives two-cycle off-times, mode 2 long ones
    always @(negedge clk) begin
        pwm_cnt <= (pwm_cnt >= 89) ? 0 : pwm_cnt + 1;
        if (pwm_mode == 1) pwm <= (pwm_cnt % 40) >= 2;
        else pwm <= (pwm_mode == 2) && (pwm_cnt >= 50);
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Counts cycles until the chosen converter reaches lvl, giving up at max
    task automatic wait_on(input bit sa, input logic lvl, input int max, output int cnt);
        cnt = 0;
        while ((sa ? sa_on : conv_on) !== lvl && cnt < max) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic pulse_setup;
        set_p = 1'b1;
        @(negedge clk);
        set_p = 1'b0;
    endtask

    initial begin
        #(60000 * 4);
        failures++;
        end_sim();
    end

    initial begin
        {rst_n, sys_en, bit_en, set_p, irq_clr, sup_ok, reg_ok, ovlo} = '0;
        {port_on, slow, pwm_mode, failures, check_count} = '0;
        fault = '0;
        cyc(4);
        chk("standby", 1, standby);
        chk("discharge", 1, disch);
        chk("run", 0, conv_on);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            {sys_en, sup_ok, reg_ok, ovlo} = {rows[i].s, rows[i].p, rows[i].r, rows[i].o};
            cyc(8);
            chk("standby", rows[i].stb, standby);
            chk("regulator", rows[i].ren, reg_en);
            if (rows[i].o) chk("usb", 0, usb_en);
        end
        {sys_en, sup_ok, reg_ok, ovlo} = 4'hE;
        cyc(8);
        chk("irq", 0, irq_n);
        chk("setup", 0, setup_done);
        chk("usb", 1, usb_en);
        bit_en = 1'b1;
        {port_on, slow} = 2'b11;
        cyc(30);
        chk("unconfigured", 0, conv_on);
        pulse_setup();
        cyc(2);
        chk("setup", 1, setup_done);
        irq_clr = 1'b1;
        cyc(1);
        irq_clr = 1'b0;
        cyc(2);
        chk("irq", 1, irq_n);
        wait_on(0, 1, 20, n);
        chk("run", 1, conv_on);
        cyc(10);
        chk("discharge", 0, disch);
        v1 = vout;
        cyc(20);
        chk("ramp", 1, 13'(vout > v1 && vout < 13'(bes_pkg::VOUT_TARGET_MV)));
        cyc(SS);
        chk("target", 13'(bes_pkg::VOUT_TARGET_MV), vout);
        pwm_mode = 1;
        for (n = 0; force_ls !== 1'b1 && n < 4000; n++) cyc(1);
        chk("forced", 1, force_ls);
        for (n = 0; force_ls === 1'b1 && n < 100; n++) cyc(1);
        chk("width", 15, 13'(n));
        for (n = 15; force_ls !== 1'b1 && n < 2100; n++) cyc(1);
        chk("period", 1, 13'(n >= 1860 && n <= 1890));
        pwm_mode = 2;
        cyc(40);
        for (n = 0; force_ls !== 1'b1 && n < 2000; n++) cyc(1);
        chk("no force", 0, force_ls);
        pwm_mode = 0;
        {port_on, slow} = 2'b00;
        wait_on(0, 0, 12, n);
        chk("pin low", 0, conv_on);
        cyc(1);
        chk("discharge", 1, disch);
        port_on = 1'b1;
        wait_on(0, 1, LIM, n);
        chk("hold", 1, 13'(n >= DC - 6 && conv_on === 1'b1));
        bit_en = 1'b0;
        wait_on(0, 0, 12, n);
        chk("bit low", 0, conv_on);
        bit_en = 1'b1;
        wait_on(0, 1, LIM, n);
        for (int i = 0; i < 4; i++) begin
            fault = bes_pkg::bes_fault_t'(4'(1 << i));
            wait_on(0, 0, 12, n);
            chk("fault", 0, conv_on);
            cyc(LIM);
            fault = '0;
            wait_on(0, 1, LIM, n);
            chk("retry", 1, 13'(n >= RC && conv_on === 1'b1));
        end
        sys_en = 1'b0;
        port_on = 1'b0;
        cyc(8);
        chk("standby", 1, standby);
        chk("setup", 0, setup_done);
        sys_en = 1'b1;
        cyc(8);
        chk("irq", 0, irq_n);
        pulse_setup();
        cyc(LIM);
        chk("pin low", 0, conv_on);
        chk("sa pin low", 0, sa_on);
        port_on = 1'b1;
        wait_on(0, 1, LIM, n);
        chk("run", 1, conv_on);
        wait_on(1, 1, LIM, n);
        chk("sa run", 1, sa_on);
        port_on = 1'b0;
        wait_on(1, 0, 12, n);
        port_on = 1'b1;
        wait_on(1, 1, LIM, n);
        chk("sa retry", 1, 13'(n >= RT - 6 && sa_on === 1'b1));
        fault.ot = 1'b1;
        wait_on(1, 0, 12, n);
        cyc(LIM);
        fault = '0;
        wait_on(1, 1, LIM, n);
        chk("sa fault", 1, 13'(n >= RT && sa_on === 1'b1));
        end_sim();
    end
endmodule
